/* File: rdr_pkg.sv */
// Constants and types for the reserved debug register access responder.
// Assumes a single 200 MHz clock domain and an AXI4-Lite register bus.
package rdr_pkg;

    // Bus widths
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int STRB_W = DATA_W / 8;

    // Frames inside the slave window, each 4 KB
    localparam logic [1:0] FRAME_DEBUG   = 2'h0;
    localparam logic [1:0] FRAME_MONITOR = 2'h1;
    localparam logic [1:0] FRAME_CONTROL = 2'h2;

    // Reserved offsets inside the debug frame
    localparam logic [11:0] DBG_RSV_LO   = 12'h000;
    localparam logic [11:0] DBG_RSV_HI   = 12'hcfc;
    localparam logic [11:0] DBG_WIN_A_LO = 12'h400;
    localparam logic [11:0] DBG_WIN_A_HI = 12'h4fc;
    localparam logic [11:0] DBG_WIN_B_LO = 12'h800;
    localparam logic [11:0] DBG_WIN_B_HI = 12'h8fc;

    // Reserved offsets inside the monitor frame
    localparam logic [11:0] MON_WIN_A_LO = 12'h000;
    localparam logic [11:0] MON_WIN_A_HI = 12'h0fc;
    localparam logic [11:0] MON_WIN_B_LO = 12'h400;
    localparam logic [11:0] MON_WIN_B_HI = 12'h47c;

    // Control frame register offsets
    localparam logic [11:0] CORE_STATE_OFS = 12'h000;
    localparam logic [11:0] STATUS_OFS     = 12'h004;
    localparam logic [11:0] CAUSE_OFS      = 12'h008;

    // Core state register fields
    localparam int BIT_POWER_ON    = 0;
    localparam int BIT_DL_ACTIVE   = 1;
    localparam int BIT_DL_FLAG     = 2;
    localparam int BIT_LOCK_FLAG   = 3;
    localparam int BIT_DBG_ALLOWED = 4;
    localparam int BIT_MON_ALLOWED = 5;
    localparam int CORE_STATE_W    = 6;
    localparam logic [5:0] CORE_STATE_RST = 6'h31;

    // Status register: sticky clear-after-read bits, then live flag
    localparam int STICKY_W        = 2;
    localparam logic [1:0] STICKY_RST = 2'h0;
    localparam int STATUS_DL_POS   = 6;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // Why an access was refused, one bit per cause
    typedef enum logic [5:0] {
        CAUSE_NONE             = 6'h01,
        CAUSE_POWER_OFF        = 6'h02,
        CAUSE_DOUBLE_LOCK      = 6'h04,
        CAUSE_LOCK             = 6'h08,
        CAUSE_DEBUG_ACCESS_DENIED   = 6'h10,
        CAUSE_MONITOR_ACCESS_DENIED = 6'h20
    } rdr_cause_t;

    // Address classes
    typedef enum logic [6:0] {
        REG_DBG_WIN    = 7'h01,
        REG_DBG_RSV    = 7'h02,
        REG_MON_WIN    = 7'h04,
        REG_CORE_STATE = 7'h08,
        REG_STATUS     = 7'h10,
        REG_CAUSE      = 7'h20,
        REG_UNMAPPED   = 7'h40
    } rdr_region_t;

    // Bus channel state machines
    typedef enum logic [1:0] {
        WR_IDLE = 2'h1,
        WR_RESP = 2'h2
    } rdr_wr_state_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'h1,
        RD_RESP = 2'h2
    } rdr_rd_state_t;

endpackage

/* File: rdr_reserved_access.sv */
// Responder for external debugger accesses to reserved debug and monitor
// offsets, with the core power and lock state held in a control register.
// Assumes an AXI4-Lite master on aclk and pulsed sticky events from the core.
`timescale 1ns/100ps
`default_nettype none

module rdr_reserved_access
    import rdr_pkg::*;
(
    input  wire logic                      aclk,    // 200 MHz clock
    input  wire logic                      aresetn, // Sync reset, low
    input  wire logic [rdr_pkg::ADDR_W-1:0] awaddr,  // Write address
    input  wire logic                      awvalid, // Write address valid
    output logic                           awready, // Write address ready
    input  wire logic [rdr_pkg::DATA_W-1:0] wdata,   // Write data
    input  wire logic [rdr_pkg::STRB_W-1:0] wstrb,   // Write byte lanes
    input  wire logic                      wvalid,  // Write data valid
    output logic                           wready,  // Write data ready
    output logic [1:0]                     bresp,   // Write response
    output logic                           bvalid,  // Write response valid
    input  wire logic                      bready,  // Write response ready
    input  wire logic [rdr_pkg::ADDR_W-1:0] araddr,  // Read address
    input  wire logic                      arvalid, // Read address valid
    output logic                           arready, // Read address ready
    output logic [rdr_pkg::DATA_W-1:0]     rdata,   // Read data
    output logic [1:0]                     rresp,   // Read response
    output logic                           rvalid,  // Read data valid
    input  wire logic                      rready,  // Read data ready
    input  wire logic [rdr_pkg::STICKY_W-1:0] sticky_set // Core event pulses
);
    import rdr_pkg::*;

    logic [CORE_STATE_W-1:0] core_state_reg;
    logic [STICKY_W-1:0]     sticky_reg;
    rdr_cause_t              cause_reg;
    rdr_wr_state_t           wr_state_reg;
    rdr_rd_state_t           rd_state_reg;
    logic                    aw_got_reg;
    logic                    w_got_reg;
    logic [ADDR_W-1:0]       awaddr_reg;
    logic [DATA_W-1:0]       wdata_reg;
    logic [STRB_W-1:0]       wstrb_reg;
    logic                    awready_reg;
    logic                    wready_reg;
    logic                    bvalid_reg;
    logic [1:0]              bresp_reg;
    logic                    arready_reg;
    logic                    rvalid_reg;
    logic [1:0]              rresp_reg;
    logic [DATA_W-1:0]       rdata_reg;

    logic        rd_take;
    logic        wr_fire;
    rdr_region_t rd_region;
    rdr_region_t wr_region;
    rdr_cause_t  rd_cause;
    rdr_cause_t  wr_cause;
    logic        sticky_hold;
    // Sort an address into one of the address classes
    function automatic rdr_region_t region_of(input logic [ADDR_W-1:0] a);
        logic [1:0]  frame;
        logic [11:0] ofs;
        frame = a[ADDR_W-1:12];
        ofs   = {a[11:2], 2'h0};
        region_of = REG_UNMAPPED;
        if (frame == FRAME_DEBUG) begin
            if ((ofs >= DBG_WIN_A_LO && ofs <= DBG_WIN_A_HI) ||
                (ofs >= DBG_WIN_B_LO && ofs <= DBG_WIN_B_HI)) begin
                region_of = REG_DBG_WIN;
            end else if (ofs >= DBG_RSV_LO && ofs <= DBG_RSV_HI) begin
                region_of = REG_DBG_RSV;
            end
        end else if (frame == FRAME_MONITOR) begin
            if ((ofs >= MON_WIN_A_LO && ofs <= MON_WIN_A_HI) ||
                (ofs >= MON_WIN_B_LO && ofs <= MON_WIN_B_HI)) begin
                region_of = REG_MON_WIN;
            end
        end else if (frame == FRAME_CONTROL) begin
            if (ofs == CORE_STATE_OFS) begin
                region_of = REG_CORE_STATE;
            end else if (ofs == STATUS_OFS) begin
                region_of = REG_STATUS;
            end else if (ofs == CAUSE_OFS) begin
                region_of = REG_CAUSE;
            end
        end
    endfunction

    // Prioritised refusal check; first matching cause wins
    function automatic rdr_cause_t cause_of(input rdr_region_t r,
                                            input logic [5:0] s);
        cause_of = CAUSE_NONE;
        if (r == REG_DBG_WIN || r == REG_DBG_RSV || r == REG_MON_WIN) begin
            if (!s[BIT_POWER_ON]) begin
                cause_of = CAUSE_POWER_OFF;
            end else if (s[BIT_DL_ACTIVE] && s[BIT_DL_FLAG]) begin
                cause_of = CAUSE_DOUBLE_LOCK;
            end else if (s[BIT_LOCK_FLAG]) begin
                cause_of = CAUSE_LOCK;
            end else if (r != REG_DBG_RSV && !s[BIT_DBG_ALLOWED]) begin
                cause_of = CAUSE_DEBUG_ACCESS_DENIED;
            end else if (r == REG_MON_WIN && !s[BIT_MON_ALLOWED]) begin
                cause_of = CAUSE_MONITOR_ACCESS_DENIED;
            end
        end
    endfunction
    // Reserved, refused accesses answer error; allowed ones read as zero
    function automatic logic [1:0] resp_of(input rdr_region_t r,
                                           input rdr_cause_t c);
        resp_of = (r == REG_UNMAPPED) ? RESP_DECERR :
                  (c != CAUSE_NONE)   ? RESP_SLVERR : RESP_OKAY;
    endfunction

    // Decode for both channels
    assign rd_region = region_of(araddr);
    assign wr_region = region_of(awaddr_reg);
    assign rd_cause  = cause_of(rd_region, core_state_reg);
    assign wr_cause  = cause_of(wr_region, core_state_reg);
    assign rd_take   = arvalid && arready_reg;
    assign wr_fire   = (wr_state_reg == WR_IDLE) && aw_got_reg && w_got_reg;
    // Write channel: address and data taken in either order, then answer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= WR_IDLE;
            aw_got_reg   <= 1'b0;
            w_got_reg    <= 1'b0;
            awaddr_reg   <= '0;
            wdata_reg    <= '0;
            wstrb_reg    <= '0;
            awready_reg  <= 1'b1;
            wready_reg   <= 1'b1;
            bvalid_reg   <= 1'b0;
            bresp_reg    <= RESP_OKAY;
        end else begin
            case (wr_state_reg)
                WR_IDLE: begin
                    if (awvalid && awready_reg) begin
                        aw_got_reg  <= 1'b1;
                        awaddr_reg  <= awaddr;
                        awready_reg <= 1'b0;
                    end
                    if (wvalid && wready_reg) begin
                        w_got_reg  <= 1'b1;
                        wdata_reg  <= wdata;
                        wstrb_reg  <= wstrb;
                        wready_reg <= 1'b0;
                    end
                    if (wr_fire) begin
                        aw_got_reg   <= 1'b0;
                        w_got_reg    <= 1'b0;
                        bvalid_reg   <= 1'b1;
                        bresp_reg    <= resp_of(wr_region, wr_cause);
                        wr_state_reg <= WR_RESP;
                    end
                end
                WR_RESP: begin
                    if (bready) begin
                        bvalid_reg   <= 1'b0;
                        awready_reg  <= 1'b1;
                        wready_reg   <= 1'b1;
                        wr_state_reg <= WR_IDLE;
                    end
                end
                default: begin
                    wr_state_reg <= WR_IDLE;
                end
            endcase
        end
    end

    // Read channel: answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_reg <= RD_IDLE;
            arready_reg  <= 1'b1;
            rvalid_reg   <= 1'b0;
            rresp_reg    <= RESP_OKAY;
            rdata_reg    <= '0;
        end else begin
            case (rd_state_reg)
                RD_IDLE: begin
                    if (rd_take) begin
                        arready_reg  <= 1'b0;
                        rvalid_reg   <= 1'b1;
                        rresp_reg    <= resp_of(rd_region, rd_cause);
                        rd_state_reg <= RD_RESP;
                        // Reserved space always reads zero, refused or not
                        case (rd_region)
                            REG_CORE_STATE: rdata_reg <=
                                {{(DATA_W-CORE_STATE_W){1'b0}},
                                 core_state_reg};
                            REG_STATUS: rdata_reg <=
                                {{(DATA_W-STATUS_DL_POS-1){1'b0}},
                                 core_state_reg[BIT_DL_FLAG],
                                 {(STATUS_DL_POS-STICKY_W){1'b0}},
                                 sticky_reg};
                            REG_CAUSE: rdata_reg <=
                                {{(DATA_W-6){1'b0}}, cause_reg};
                            default: rdata_reg <= '0;
                        endcase
                    end
                end
                RD_RESP: begin
                    if (rready) begin
                        rvalid_reg   <= 1'b0;
                        arready_reg  <= 1'b1;
                        rd_state_reg <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state_reg <= RD_IDLE;
                end
            endcase
        end
    end
    // Core power and lock state; only the low byte lane carries it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_state_reg <= CORE_STATE_RST;
        end else if (wr_fire && wr_region == REG_CORE_STATE &&
                     wstrb_reg[0]) begin
            core_state_reg <= wdata_reg[CORE_STATE_W-1:0];
        end
    end

    // Clear-after-read is held off while the lock would hide the read
    assign sticky_hold = core_state_reg[BIT_POWER_ON] &&
                         core_state_reg[BIT_DL_ACTIVE];
    // A new event in the clearing cycle survives: set beats clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sticky_reg <= STICKY_RST;
        end else if (rd_take && rd_region == REG_STATUS && !sticky_hold) begin
            sticky_reg <= sticky_set;
        end else begin
            sticky_reg <= sticky_reg | sticky_set;
        end
    end

    // Last reserved-access verdict; a read wins over a same-cycle write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_reg <= CAUSE_NONE;
        end else if (rd_take && (rd_region == REG_DBG_WIN ||
                     rd_region == REG_DBG_RSV ||
                     rd_region == REG_MON_WIN)) begin
            cause_reg <= rd_cause;
        end else if (wr_fire && (wr_region == REG_DBG_WIN ||
                     wr_region == REG_DBG_RSV ||
                     wr_region == REG_MON_WIN)) begin
            cause_reg <= wr_cause;
        end
    end
    // Outputs straight from flip-flops
    assign awready = awready_reg;
    assign wready  = wready_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;
    assign arready = arready_reg;
    assign rvalid  = rvalid_reg;
    assign rresp   = rresp_reg;
    assign rdata   = rdata_reg;

    // Checks on the responder's own answers
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    logic rd_rsv;
    assign rd_rsv = rd_region == REG_DBG_WIN || rd_region == REG_DBG_RSV ||
                    rd_region == REG_MON_WIN;
    sequence s_rd_err;
        rvalid_reg && rresp_reg == RESP_SLVERR && rdata_reg == '0;
    endsequence
    sequence s_rd_ok_zero;
        rvalid_reg && rresp_reg == RESP_OKAY && rdata_reg == '0;
    endsequence
    property p_power_off;
        rd_take && rd_rsv && !core_state_reg[BIT_POWER_ON] |=> s_rd_err;
    endproperty
    a_power_off: assert property (p_power_off)
        else $error("reserved read with power off not refused");
    property p_double_lock;
        rd_take && rd_rsv && core_state_reg[BIT_DL_ACTIVE] &&
        core_state_reg[BIT_DL_FLAG] |=> s_rd_err;
    endproperty
    a_double_lock: assert property (p_double_lock)
        else $error("reserved read under double lock not refused");
    property p_lock;
        rd_take && rd_rsv && core_state_reg[BIT_LOCK_FLAG] |=> s_rd_err;
    endproperty
    a_lock: assert property (p_lock)
        else $error("reserved read under lock not refused");
    property p_debug_denied;
        rd_take && rd_region == REG_DBG_WIN &&
        !core_state_reg[BIT_DBG_ALLOWED] |=> s_rd_err;
    endproperty
    a_debug_denied: assert property (p_debug_denied)
        else $error("debug window read not refused");
    property p_monitor_denied;
        rd_take && rd_region == REG_MON_WIN &&
        !core_state_reg[BIT_MON_ALLOWED] |=> s_rd_err;
    endproperty
    a_monitor_denied: assert property (p_monitor_denied)
        else $error("monitor window read not refused");
    property p_monitor_allowed;
        rd_take && rd_region == REG_MON_WIN &&
        core_state_reg == CORE_STATE_RST |=> s_rd_ok_zero;
    endproperty
    a_monitor_allowed: assert property (p_monitor_allowed)
        else $error("permitted monitor read did not read zero");
    property p_sticky_hold;
        sticky_hold |=> (sticky_reg & $past(sticky_reg)) == $past(sticky_reg);
    endproperty
    a_sticky_hold: assert property (p_sticky_hold)
        else $error("sticky bit cleared under double lock");
    // Power off must be reported even when debug access is also barred
    property p_priority;
        rd_take && rd_rsv && !core_state_reg[BIT_POWER_ON] &&
        !core_state_reg[BIT_DBG_ALLOWED] |=>
        s_rd_err ##0 cause_reg == CAUSE_POWER_OFF;
    endproperty
    a_priority: assert property (p_priority)
        else $error("power check did not take priority");
    property p_write_answer;
        wr_fire |=> bvalid_reg ##0 !awready_reg && !wready_reg;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("write answer late or channels not closed");

endmodule

`default_nettype wire

/* File: rdr_dbg_master.sv */
// Behavioural model of the external debugger on the AXI4-Lite debug bus.
// Assumes one access at a time, started by a one-cycle go from the bench.
`timescale 1ns/100ps
`default_nettype none

module rdr_dbg_master (
    input  wire logic        aclk,    // Bus clock
    input  wire logic        aresetn, // Sync reset, low
    input  wire logic        go,      // Start one access
    input  wire logic        wr,      // 1 write, 0 read
    input  wire logic [13:0] addr,    // Byte address
    input  wire logic [31:0] data,    // Write data
    output logic             done,    // Answer taken, one cycle
    output logic [1:0]       resp,    // Response code taken
    output logic [31:0]      rd,      // Read data taken
    output logic [13:0]      awaddr,  // Write address
    output logic             awvalid, // Write address valid
    input  wire logic        awready, // Write address ready
    output logic [31:0]      wdata,   // Write data
    output logic [3:0]       wstrb,   // Write lanes
    output logic             wvalid,  // Write data valid
    input  wire logic        wready,  // Write data ready
    input  wire logic [1:0]  bresp,   // Write response
    input  wire logic        bvalid,  // Write response valid
    output logic             bready,  // Write response ready
    output logic [13:0]      araddr,  // Read address
    output logic             arvalid, // Read address valid
    input  wire logic        arready, // Read address ready
    input  wire logic [31:0] rdata,   // Read data
    input  wire logic [1:0]  rresp,   // Read response
    input  wire logic        rvalid,  // Read data valid
    output logic             rready   // Read data ready
);
    // Each channel holds until its own ready; released payloads are
    // inverted so a slave that samples late never sees stale values
    always_ff @(posedge aclk) begin
        done <= 1'b0;
        if (!aresetn) begin
            awvalid <= 1'b0;
            wvalid  <= 1'b0;
            arvalid <= 1'b0;
            bready  <= 1'b0;
            rready  <= 1'b0;
            awaddr  <= 14'h0000;
            araddr  <= 14'h0000;
            wdata   <= 32'h00000000;
            wstrb   <= 4'h0;
        end else if (go && wr) begin
            awvalid <= 1'b1;
            wvalid  <= 1'b1;
            bready  <= 1'b1;
            awaddr  <= addr;
            wdata   <= data;
            wstrb   <= 4'hf;
        end else if (go) begin
            arvalid <= 1'b1;
            rready  <= 1'b1;
            araddr  <= addr;
        end else begin
            if (awvalid && awready) begin
                awvalid <= 1'b0;
                awaddr  <= ~awaddr;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
                wdata  <= ~wdata;
                wstrb  <= ~wstrb;
            end
            if (arvalid && arready) begin
                arvalid <= 1'b0;
                araddr  <= ~araddr;
            end
            if (bready && bvalid) begin
                bready <= 1'b0;
                resp   <= bresp;
                done   <= 1'b1;
            end
            if (rready && rvalid) begin
                rready <= 1'b0;
                resp   <= rresp;
                rd     <= rdata;
                done   <= 1'b1;
            end
        end
    end
endmodule

`default_nettype wire

/* File: rdr_reserved_access_tb.sv */
// Self-checking bench for the reserved debug access responder.
// Assumes the debugger model drives the bus; bench drives core events.
`timescale 1ns/100ps
`default_nettype none

`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
    failures++; $display("mismatch t=%0t got %h exp %h", $time, got, exp); \
    end end

module rdr_reserved_access_tb;
    import rdr_pkg::*;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic        go = 1'b0, m_wr = 1'b0, done;
    logic [13:0] m_addr = 14'h0000, awaddr, araddr;
    logic [31:0] m_data = 32'h0, m_rd, wdata, rdata;
    logic [1:0]  m_resp, bresp, rresp, sticky_set = 2'h0;
    logic [3:0]  wstrb;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    int          failures = 0, tests_run = 0, cycles = 0;

    always #2.5 aclk = ~aclk;

    rdr_reserved_access u_dut (.aclk(aclk), .aresetn(aresetn),
        .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .sticky_set(sticky_set));

    rdr_dbg_master u_dbg (.aclk(aclk), .aresetn(aresetn), .go(go),
        .wr(m_wr), .addr(m_addr), .data(m_data), .done(done),
        .resp(m_resp), .rd(m_rd), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    task automatic summarize();
        $display("failures=%0d tests_run=%0d", failures, tests_run);
        if (failures == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Ceiling well above the few hundred cycles the scenarios need
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            summarize();
        end
    end

    // One access through the model; waits for its answer, bounded
    task automatic acc(input logic w, input logic [13:0] a,
                       input logic [31:0] d, output logic [1:0] r,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge aclk);
        go <= 1'b1;
        m_wr <= w;
        m_addr <= a;
        m_data <= d;
        @(posedge aclk);
        go <= 1'b0;
        #1;
        while (done !== 1'b1 && n < 200) begin
            @(posedge aclk);
            #1;
            n++;
        end
        if (n >= 200) begin
            failures++;
            summarize();
        end else begin
            r = m_resp;
            q = m_rd;
        end
    endtask

    task automatic rd(input logic [13:0] a, input logic [1:0] er,
                      input logic [31:0] ed);
        logic [1:0]  r;
        logic [31:0] q;
        acc(1'b0, a, 32'h0, r, q);
        `CHK(r, er)
        `CHK(q, ed)
    endtask

    task automatic wr(input logic [13:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic [1:0]  r;
        logic [31:0] q;
        acc(1'b1, a, d, r, q);
        `CHK(r, er)
    endtask

    task automatic state(input logic [5:0] v);
        wr(14'h2000, {26'h0, v}, RESP_OKAY);
    endtask

    task automatic cause(input logic [5:0] c);
        rd(14'h2008, RESP_OKAY, {26'h0, c});
    endtask

    // Power off refuses debug and monitor reserved places alike
    task automatic t_power();
        rd(14'h2000, RESP_OKAY, 32'h31);
        rd(14'h0d00, RESP_DECERR, 32'h0);
        rd(14'h1400, RESP_OKAY, 32'h0);
        cause(6'h01);
        state(6'h30);
        rd(14'h0000, RESP_SLVERR, 32'h0);
        cause(6'h02);
        wr(14'h1000, 32'h5, RESP_SLVERR);
    endtask

    // Double lock needs both the active status and the flag
    task automatic t_locks();
        state(6'h35);
        rd(14'h0cfc, RESP_OKAY, 32'h0);
        cause(6'h01);
        state(6'h37);
        rd(14'h0cfc, RESP_SLVERR, 32'h0);
        cause(6'h04);
        state(6'h39);
        wr(14'h0400, 32'h1, RESP_SLVERR);
        cause(6'h08);
    endtask

    // Debug check covers both debug windows and the monitor windows, not other debug reserved places
    task automatic t_debug();
        state(6'h21);
        rd(14'h04fc, RESP_SLVERR, 32'h0);
        cause(6'h10);
        rd(14'h0800, RESP_SLVERR, 32'h0);
        rd(14'h0500, RESP_OKAY, 32'h0);
        rd(14'h1000, RESP_SLVERR, 32'h0);
    endtask

    // Monitor check at the upper edge of both windows
    task automatic t_monitor();
        state(6'h11);
        rd(14'h147c, RESP_SLVERR, 32'h0);
        cause(6'h20);
        wr(14'h10fc, 32'h2, RESP_SLVERR);
        rd(14'h0400, RESP_OKAY, 32'h0);
        rd(14'h1480, RESP_DECERR, 32'h0);
    endtask

    // Several causes at once: the highest one is reported
    task automatic t_order();
        state(6'h0e);
        rd(14'h1400, RESP_SLVERR, 32'h0);
        cause(6'h02);
        state(6'h0f);
        rd(14'h1400, RESP_SLVERR, 32'h0);
        cause(6'h04);
        state(6'h09);
        rd(14'h1400, RESP_SLVERR, 32'h0);
        cause(6'h08);
    endtask

    // Sticky bits survive reads only while powered with the double lock active bit set
    task automatic t_sticky();
        state(6'h37);
        @(posedge aclk);
        sticky_set <= 2'h3;
        @(posedge aclk);
        sticky_set <= 2'h0;
        rd(14'h2004, RESP_OKAY, 32'h43);
        rd(14'h2004, RESP_OKAY, 32'h43);
        state(6'h32);
        rd(14'h2004, RESP_OKAY, 32'h03);
        rd(14'h2004, RESP_OKAY, 32'h00);
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_power();
        t_locks();
        t_debug();
        t_monitor();
        t_order();
        t_sticky();
        summarize();
    end
endmodule

`default_nettype wire
